// file: inc/fault_sup_consts.vh
// Function
// - overtemp: gate off, flag, discharge soft-start
// - overtemp restart with soft-start after hysteresis
// - current limit ends switch on-time each cycle
// - current limit over 64 counts: hiccup
// - blank current limit, undervoltage for 3 ms
// - LED overcurrent: drives off, hiccup after 2
// - output undervoltage: drives off; 30 counts hiccup
// - overvoltage: drives off, flag, hiccup after 1
// - supply undervoltage: drives off, restart on recovery
// - rail undervoltage: gate off, flag, auto restart
// - dimming supply undervoltage: drives off, restart
// - timing pin fault selects 350 kHz
// - loop node short forces minimum duty
// - hiccup interval lasts 26.5 ms
// - slow external clock reverts to internal oscillator
// - blanking also after sleep exit, hiccup
`ifndef FAULT_SUP_CONSTS_VH
`define FAULT_SUP_CONSTS_VH
`define CLK_HZ 50000000
`define BLANK_US 3000
`define BLANK_CYCLES ((`BLANK_US * (`CLK_HZ / 1000000)))
`define HICCUP_NS 26500000
`define HICCUP_CYCLES ((`HICCUP_NS / 1000) * (`CLK_HZ / 1000000))
`define WDOG_NS 17000
`define WDOG_CYCLES (`WDOG_NS / 20)
`define INT_OSC_KHZ 350
`define INT_OSC_HALF ((`CLK_HZ / (`INT_OSC_KHZ * 1000)) / 2)
`define CL_LIMIT 64
`define OC_LIMIT 2
`define UV_LIMIT 30
`define OV_LIMIT 1
`define CNT_W 7
`endif

// file: rtl/led_driver_fault_supervisor.v
`timescale 1ns/1ns
`include "fault_sup_consts.vh"
module led_driver_fault_supervisor #(
  parameter BLANK_CYCLES = `BLANK_CYCLES,
  parameter HICCUP_CYCLES = `HICCUP_CYCLES,
  parameter WDOG_CYCLES = `WDOG_CYCLES,
  parameter INT_OSC_HALF = `INT_OSC_HALF
) (
  input wire core_clk,
  input wire rst_n,
  input wire pwm_request,
  input wire switch_current_limit,
  input wire led_overcurrent,
  input wire output_undervoltage,
  input wire fixed_overvoltage,
  input wire prog_overvoltage,
  input wire supply_input_uv,
  input wire internal_5v_rail_uv,
  input wire dimming_supply_uv,
  input wire overtemp,
  input wire timing_resistor_pin_fault,
  input wire timing_resistor_pin,
  input wire comp_short,
  output wire osc_clk,
  output wire osc_cycle,
  output wire force_min_duty,
  output reg low_side_gate_drive,
  output reg dimming_switch_drive,
  output reg fault_flag_n,
  output reg soft_start_discharge
);
  localparam ST_RUN = 3'b001;
  localparam ST_MASK = 3'b010;
  localparam ST_HIC = 3'b100;
  // sync every pin-level input, two stages
  localparam NIN = 13;
  wire [NIN-1:0] raw = {
    comp_short,
    timing_resistor_pin,
    timing_resistor_pin_fault,
    overtemp,
    dimming_supply_uv,
    internal_5v_rail_uv,
    supply_input_uv,
    prog_overvoltage,
    fixed_overvoltage,
    output_undervoltage,
    led_overcurrent,
    switch_current_limit,
    pwm_request
  };
  wire [NIN-1:0] syn;
  // bits are independent levels, so one shared stage pair needs no word coherence
  sync_2ff #(
    .W(NIN)
  ) pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(raw),
    .q(syn)
  );
  wire s_pwm = syn[0];
  wire s_cl = syn[1];
  wire s_oc = syn[2];
  wire s_ouv = syn[3];
  wire s_ov = syn[4] | syn[5];
  wire s_vin = syn[6];
  wire s_internal_5v_rail = syn[7];
  wire s_dimuv = syn[8];
  wire s_ot = syn[9];
  wire s_pinf = syn[10];
  wire s_ext = syn[11];
  wire s_comp = syn[12];
  // internal oscillator, enable pulse per period
  reg [15:0] int_div;
  reg int_ph;
  reg int_tick;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_div <= 16'h0000;
      int_ph <= 1'b0;
      int_tick <= 1'b0;
    end else begin
      int_tick <= 1'b0;
      if (int_div >= INT_OSC_HALF[15:0] - 16'h0001) begin
        int_div <= 16'h0000;
        int_ph <= ~int_ph;
        int_tick <= int_ph;
      end else begin
        int_div <= int_div + 16'h0001;
      end
    end
  end
  // external clock watchdog: period at or above limit falls back
  reg ext_d;
  reg [15:0] ext_cnt;
  reg ext_ok;
  wire ext_rise = s_ext & ~ext_d;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_d <= 1'b0;
      ext_cnt <= 16'h0000;
      ext_ok <= 1'b0;
    end else begin
      ext_d <= s_ext;
      if (ext_rise) begin
        ext_cnt <= 16'h0000;
        ext_ok <= (ext_cnt < WDOG_CYCLES[15:0] - 16'h0001);
      end else if (ext_cnt >= WDOG_CYCLES[15:0] - 16'h0001) begin
        ext_ok <= 1'b0;
      end else begin
        ext_cnt <= ext_cnt + 16'h0001;
      end
    end
  end
  wire use_ext = ext_ok & ~s_pinf;
  assign osc_cycle = use_ext ? ext_rise : int_tick;
  assign osc_clk = use_ext ? s_ext : int_ph;
  assign force_min_duty = s_comp;
  // persistence counters, one per oscillator cycle
  wire [`CNT_W-1:0] cl_cnt;
  wire [`CNT_W-1:0] oc_cnt;
  wire [`CNT_W-1:0] uv_cnt;
  wire [`CNT_W-1:0] ov_cnt;
  reg [2:0] state;
  reg [23:0] hic_cnt;
  reg [23:0] blank_cnt;
  reg init_done;
  reg hold_prev;
  // blanking only masks the slowly building faults; overvoltage is never blanked
  wire blanking = (blank_cnt != 24'h000000);
  wire cl_q = s_cl & ~blanking;
  wire uv_q = s_ouv & ~blanking;
  wire cl_trip = cl_q && osc_cycle && cl_cnt >= `CL_LIMIT;
  wire oc_trip = s_oc && osc_cycle && oc_cnt >= `OC_LIMIT - 1;
  wire uv_trip = uv_q && osc_cycle && uv_cnt >= `UV_LIMIT;
  wire ov_trip = s_ov && osc_cycle && ov_cnt >= `OV_LIMIT - 1;
  wire any_trip = cl_trip | oc_trip | uv_trip | ov_trip;
  // level faults hold the switcher off until they clear
  wire hold_ss = s_ot | s_vin | s_dimuv;
  wire hold = hold_ss | s_internal_5v_rail;
  // counters clear outside run so every restart counts from zero
  fault_persist #(
    .W(`CNT_W)
  ) cl_persist (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(state != ST_RUN),
    .step(osc_cycle),
    .fault(cl_q),
    .count(cl_cnt)
  );
  fault_persist #(
    .W(`CNT_W)
  ) oc_persist (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(state != ST_RUN),
    .step(osc_cycle),
    .fault(s_oc),
    .count(oc_cnt)
  );
  fault_persist #(
    .W(`CNT_W)
  ) uv_persist (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(state != ST_RUN),
    .step(osc_cycle),
    .fault(uv_q),
    .count(uv_cnt)
  );
  fault_persist #(
    .W(`CNT_W)
  ) ov_persist (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(state != ST_RUN),
    .step(osc_cycle),
    .fault(s_ov),
    .count(ov_cnt)
  );
  // hiccup sequencer
  reg [2:0] next_state;
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (oc_trip | ov_trip) begin
          next_state = ST_MASK;
        end else if (cl_trip | uv_trip) begin
          next_state = ST_HIC;
        end
      end
      ST_MASK: begin
        if (osc_cycle) begin
          next_state = ST_HIC;
        end
      end
      ST_HIC: begin
        if (hic_cnt >= HICCUP_CYCLES[23:0] - 24'h000001) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end
  wire hic_end = (state == ST_HIC) && (next_state == ST_RUN);
  wire hold_exit = hold_prev & ~hold;
  // first dimming request after reset stands in for leaving sleep
  wire sleep_exit = s_pwm & ~init_done;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
      hic_cnt <= 24'h000000;
      blank_cnt <= 24'h000000;
      init_done <= 1'b0;
      hold_prev <= 1'b0;
    end else begin
      state <= next_state;
      hold_prev <= hold;
      hic_cnt <= (state == ST_HIC) ? hic_cnt + 24'h000001 : 24'h000000;
      if (s_pwm) begin
        init_done <= 1'b1;
      end
      // sleep exit, startup, hiccup end, restart all re-blank
      if (sleep_exit | hic_end | hold_exit) begin
        blank_cnt <= BLANK_CYCLES[23:0];
      end else if (blanking) begin
        blank_cnt <= blank_cnt - 24'h000001;
      end
    end
  end
  // registered drives; one cycle late, accepted to keep outputs glitch free
  wire latched = (state != ST_RUN);
  wire both_off = latched | s_oc | s_ouv | s_ov | s_vin | s_dimuv;
  wire gate_off = both_off | s_ot | s_internal_5v_rail | cl_q | s_cl;
  // undervoltage alone keeps the flag quiet until its count runs out
  wire flag_cause = latched | any_trip | s_oc | s_ov | hold | (s_ouv & (uv_cnt >= `UV_LIMIT));
  wire discharge_cause = (state == ST_HIC) | (next_state == ST_HIC) | hold_ss | ~init_done;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_side_gate_drive <= 1'b0;
      dimming_switch_drive <= 1'b0;
      fault_flag_n <= 1'b1;
      soft_start_discharge <= 1'b1;
    end else begin
      low_side_gate_drive <= s_pwm & ~gate_off & ~(s_comp & osc_cycle);
      dimming_switch_drive <= s_pwm & ~both_off;
      fault_flag_n <= ~flag_cause;
      soft_start_discharge <= discharge_cause;
    end
  end
endmodule

module sync_2ff #(
  parameter W = 1
) (
  input wire core_clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  // only q is read downstream; meta may settle late
  reg [W-1:0] meta;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

module fault_persist #(
  parameter W = 7
) (
  input wire core_clk,
  input wire rst_n,
  input wire clear,
  input wire step,
  input wire fault,
  output reg [W-1:0] count
);
  // saturates so a very long fault never wraps back under its limit
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {W{1'b0}};
    end else if (clear) begin
      count <= {W{1'b0}};
    end else if (step) begin
      if (!fault) begin
        count <= {W{1'b0}};
      end else if (count != {W{1'b1}}) begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// file: verif/fault_sup_checker.sv
`timescale 1ns/1ns
module fault_sup_checker(
  input wire core_clk, rst_n, overtemp, led_overcurrent, fixed_overvoltage, supply_input_uv,
  input wire dimming_supply_uv, comp_short, force_min_duty, osc_cycle, low_side_gate_drive,
  input wire dimming_switch_drive, fault_flag_n, soft_start_discharge
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_off; !low_side_gate_drive && !dimming_switch_drive && !fault_flag_n; endsequence
  property p_ot; overtemp[*4] |-> !low_side_gate_drive && !fault_flag_n; endproperty
  a_ot: assert property (p_ot) else $error("overtemp");
  property p_oc; led_overcurrent[*4] |-> s_off; endproperty
  a_oc: assert property (p_oc) else $error("led");
  property p_ov; fixed_overvoltage[*4] |-> s_off; endproperty
  a_ov: assert property (p_ov) else $error("ov");
  property p_suv; supply_input_uv[*4] |-> s_off; endproperty
  a_suv: assert property (p_suv) else $error("supply");
  property p_duv; dimming_supply_uv[*4] |-> s_off; endproperty
  a_duv: assert property (p_duv) else $error("dim");
  property p_cs; comp_short[*3] |-> force_min_duty; endproperty
  a_cs: assert property (p_cs) else $error("duty");
  property p_ncs; (!comp_short)[*3] |-> !force_min_duty; endproperty
  a_ncs: assert property (p_ncs) else $error("duty");
  property p_osc; osc_cycle |=> !osc_cycle; endproperty
  a_osc: assert property (p_osc) else $error("pulse");
endmodule

// file: verif/sync_clock_model.sv
`timescale 1ns/1ns
module sync_clock_model #(
  parameter HALF_NS = 2000
) (
  input wire run,
  output reg clk_out
);
  // held low when stopped, as a dead external clock looks
  initial clk_out = 1'h0;
  always #HALF_NS clk_out = run ? ~clk_out : 1'h0;
endmodule

// file: verif/led_driver_fault_supervisor_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("ERROR %0t %h %h", $time, a, b); end end
module led_driver_fault_supervisor_tb;
  reg clk = 1'h0, rst_n = 1'h0, run = 1'h0;
  reg [10:0] f = 11'h000;
  wire x, p, fmd, gate, dim, flag_n, dis;
  integer fails = 0, check_count = 0, i;
  always #10 clk = ~clk;
  sync_clock_model m (.run(run), .clk_out(x));
  led_driver_fault_supervisor #(.BLANK_CYCLES(50), .HICCUP_CYCLES(100)) dut (.core_clk(clk), .rst_n(rst_n),
    .pwm_request(rst_n), .switch_current_limit(f[0]), .led_overcurrent(f[1]), .output_undervoltage(f[2]),
    .fixed_overvoltage(f[3]), .prog_overvoltage(f[4]), .supply_input_uv(f[5]), .internal_5v_rail_uv(f[6]),
    .dimming_supply_uv(f[7]), .overtemp(f[8]), .timing_resistor_pin_fault(f[9]), .timing_resistor_pin(x),
    .comp_short(f[10]), .osc_clk(), .osc_cycle(p), .force_min_duty(fmd), .low_side_gate_drive(gate),
    .dimming_switch_drive(dim), .fault_flag_n(flag_n), .soft_start_discharge(dis));
  task summarize;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task restart;
    rst_n = 1'h0;
    cyc(5);
    rst_n = 1'h1;
  endtask
  task run_len(input s, input v);
    for (i = 0; i < 500 && (s ? p : dis) === v; i++) cyc(1);
    `CHK(i < 500, 1'h1)
    if (i == 500) summarize;
  endtask
  task t_faults;
    for (i = 1; i < 9; i++) if (i != 2) begin
      restart;
      f[i] = 1'h1;
      cyc(5);
      `CHK({flag_n, gate}, 2'h0)
      if (i < 6 || i == 7) `CHK(dim, 1'h0)
      if (i == 8) `CHK(dis, 1'h1)
      f[i] = 1'h0;
    end
    $display("faults end");
  endtask
  task t_hic;
    restart;
    run_len(1'h0, 1'h1);
    f[3] = 1'h1;
    run_len(1'h0, 1'h0);
    `CHK(i < 290, 1'h1)
    f[3] = 1'h0;
    run_len(1'h0, 1'h1);
    `CHK(i > 98 && i < 103, 1'h1)
    $display("hiccup end");
  endtask
  // persistent current limit or undervoltage: n faulted oscillator periods, then hiccup
  task t_persist(input integer b, input integer n);
    restart;
    cyc(60);
    f[b] = 1'h1;
    cyc(5);
    `CHK({flag_n, dim}, {1'h1, b == 0})
    `CHK(gate, 1'h0)
    for (i = 0; i < 12000 && dis === 1'h0; i++) cyc(1);
    `CHK(i > (n - 1) * 142 && i < (n + 1) * 142, 1'h1)
    cyc(1);
    `CHK({flag_n, dim}, 2'h0)
    f[b] = 1'h0;
    if (i == 12000) summarize;
    $display("persist end");
  endtask
  // low run between pulses, one short of two 71-cycle halves
  task meas;
    run_len(1'h1, 1'h0);
    cyc(1);
    run_len(1'h1, 1'h0);
  endtask
  task t_osc;
    run = 1'h1;
    cyc(400);
    f[10:9] = 2'h3;
    meas;
    `CHK(i, 141)
    `CHK(fmd, 1'h1)
    {f[10:9], run} = 3'h0;
    cyc(1000);
    meas;
    `CHK(i, 141)
    `CHK(fmd, 1'h0)
    $display("osc end");
  endtask
  initial begin
    restart;
    t_faults;
    t_hic;
    t_persist(0, 64);
    t_persist(2, 30);
    t_osc;
    summarize;
  end
endmodule
bind led_driver_fault_supervisor fault_sup_checker chk (.*);
